/* File: include/virq_pkg.sv */
// Purpose: shared constants and types for the vectored interrupt priority logic
// Assumes: vectors 2..33 only; two program words per table slot
// Notes: vector 0 and 1 are reset slots and never arbitrated
package virq_pkg;

    localparam int NUM_VEC = 34;
    localparam int VEC_W = 6;
    localparam int LVL_W = 2;
    localparam int ADDR_W = 19;
    localparam int FIRST_CORE_VEC = 2;
    localparam int LAST_CORE_VEC = 9;
    localparam int FIRST_PERIPH_VEC = 10;
    localparam int NUM_PERIPH = 24;
    localparam int WORDS_PER_SLOT = 2;

    localparam logic [LVL_W-1:0] CORE_LEVEL = 2'h3;
    localparam logic [LVL_W-1:0] PERIPH_RESET_LEVEL = 2'h0;
    localparam logic [ADDR_W-1:0] VECTOR_TABLE_BASE_RESET = 19'h00000;

    // reset slot offsets
    localparam logic [ADDR_W-1:0] OFS_CHIP_RESET = 19'h00000;
    localparam logic [ADDR_W-1:0] OFS_WATCHDOG_RESET = 19'h00002;

    // named vectors
    localparam logic [VEC_W-1:0] VEC_ILLEGAL = 6'h02;
    localparam logic [VEC_W-1:0] VEC_STACK_OVF = 6'h03;
    localparam logic [VEC_W-1:0] VEC_MISALIGN = 6'h04;
    localparam logic [VEC_W-1:0] VEC_DBG_STEP = 6'h05;
    localparam logic [VEC_W-1:0] VEC_DBG_BRK = 6'h06;
    localparam logic [VEC_W-1:0] VEC_DBG_TRACE = 6'h07;
    localparam logic [VEC_W-1:0] VEC_DBG_TX_EMPTY = 6'h08;
    localparam logic [VEC_W-1:0] VEC_DBG_RX_FULL = 6'h09;
    localparam logic [VEC_W-1:0] VEC_POWER_MONITOR = 6'h0A;
    localparam logic [VEC_W-1:0] VEC_PWM = 6'h0E;
    localparam logic [VEC_W-1:0] VEC_CMP0 = 6'h0F;
    localparam logic [VEC_W-1:0] VEC_CMP2 = 6'h11;
    localparam logic [VEC_W-1:0] VEC_FLASH = 6'h12;
    localparam logic [VEC_W-1:0] VEC_SPI_RX = 6'h13;
    localparam logic [VEC_W-1:0] VEC_SPI_TX = 6'h14;
    localparam logic [VEC_W-1:0] VEC_SCI_TX = 6'h15;
    localparam logic [VEC_W-1:0] VEC_SCI_RX = 6'h16;
    localparam logic [VEC_W-1:0] VEC_DUAL_TIMER_CH0 = 6'h19;
    localparam logic [VEC_W-1:0] VEC_DUAL_TIMER_CH1 = 6'h1A;
    localparam logic [VEC_W-1:0] VEC_PORT_A = 6'h1B;
    localparam logic [VEC_W-1:0] VEC_PORT_F = 6'h20;
    localparam logic [VEC_W-1:0] VEC_RTC = 6'h21;

    typedef struct packed {
        logic valid;
        logic [LVL_W-1:0] level;
        logic [VEC_W-1:0] vector;
    } virq_win_type;

    typedef struct packed {
        logic req;
        logic [LVL_W-1:0] level;
        logic [VEC_W-1:0] vector;
        logic [ADDR_W-1:0] addr;
    } virq_grant_type;

    // fixed per-vector offset in program words
    function automatic logic [ADDR_W-1:0] vec_offset(input logic [VEC_W-1:0] v);
        vec_offset = ADDR_W'({v, 1'b0});
    endfunction

    // user encoding equals vector number
    function automatic logic [VEC_W-1:0] user_encoding(input logic [VEC_W-1:0] v);
        user_encoding = v;
    endfunction

endpackage

/* File: rtl/virq_arbiter.sv */
// Purpose: combinational priority pick over all pending vectors from 2 upward
// Assumes: levels given per vector, index equals vector number
// Notes: higher level wins, then lowest vector
`timescale 1ns/1ps
module virq_arbiter #(
    parameter int NV = 34
) (
    // requests
    input wire logic [NV-1:0] pend_i,
    input wire logic [NV*virq_pkg::LVL_W-1:0] level_i,
    // winner
    output virq_pkg::virq_win_type win_o
);
    import virq_pkg::*;

    // map must reach past the core vectors and fit the vector field
    if (NV < FIRST_PERIPH_VEC || NV > 2 ** VEC_W) begin : g_bad_nv
        $error("vector count outside what the arbiter can serve");
    end

    always_comb begin
        logic [LVL_W-1:0] lv;
        lv = '0;
        win_o = '0;
        // walk downward so the lowest vector at the best level wins
        for (int i = NV - 1; i >= FIRST_CORE_VEC; i--) begin
            lv = level_i[i*LVL_W +: LVL_W];
            if (pend_i[i] && (!win_o.valid || lv >= win_o.level)) begin
                win_o.valid = 1'b1;
                win_o.level = lv;
                win_o.vector = VEC_W'(i);
            end
        end
    end

endmodule

/* File: rtl/virq_ctrl.sv */
// Purpose: vectored interrupt priority controller facing the processor core
// Assumes: sources are synchronous level requests on CLK_I; core acks on CLK_I
// Notes: priorities and table base arrive as plain ports, no register bus
`timescale 1ns/1ps
module virq_ctrl #(
    parameter int NV = virq_pkg::NUM_VEC,
    parameter int NP = virq_pkg::NUM_PERIPH
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // core exception sources, vectors 2..9
    input wire logic [7:0] CORE_EXC_I,
    // peripheral sources, vectors 10..33
    input wire logic [NP-1:0] PERIPH_REQ_I,
    // configuration
    input wire logic [NP*virq_pkg::LVL_W-1:0] PERIPH_LEVEL_I,
    input wire logic PERIPH_LEVEL_WE_I,
    input wire logic [virq_pkg::ADDR_W-1:0] VECTOR_TABLE_BASE_I,
    input wire logic VECTOR_TABLE_BASE_WE_I,
    // core side
    input wire logic ACK_I,
    output virq_pkg::virq_grant_type GRANT_O,
    output logic [virq_pkg::ADDR_W-1:0] CHIP_RESET_ADDR_O,
    output logic [virq_pkg::ADDR_W-1:0] WATCHDOG_RESET_ADDR_O
);
    import virq_pkg::*;

    // the request and level maps are fixed, so the counts are too
    if (NV != NUM_VEC || NP != NV - FIRST_PERIPH_VEC) begin : g_bad_map
        $error("vector counts do not match the fixed map");
    end

    typedef enum logic {ST_IDLE, ST_HOLD} virq_state_type;

    logic [NP*LVL_W-1:0] periph_level_q;
    logic [ADDR_W-1:0] vector_table_base_q;
    logic [NV-1:0] pend;
    logic [NV*LVL_W-1:0] level_all;
    virq_win_type win;
    virq_state_type state_q;
    virq_grant_type grant_q;
    logic [ADDR_W-1:0] chip_reset_addr_q;
    logic [ADDR_W-1:0] watchdog_reset_addr_q;

    // request vector map, index equals vector number
    assign pend = {PERIPH_REQ_I, CORE_EXC_I, 2'b00};

    // level map: core fixed, peripherals programmable
    always_comb begin
        level_all = '0;
        for (int i = FIRST_CORE_VEC; i <= LAST_CORE_VEC; i++) begin
            level_all[i*LVL_W +: LVL_W] = CORE_LEVEL;
        end
        level_all[NV*LVL_W-1:FIRST_PERIPH_VEC*LVL_W] = periph_level_q;
    end

    // peripheral levels
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            periph_level_q <= {NP{PERIPH_RESET_LEVEL}};
        end else if (CE_I && PERIPH_LEVEL_WE_I) begin
            periph_level_q <= PERIPH_LEVEL_I;
        end
    end

    // table base
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            vector_table_base_q <= VECTOR_TABLE_BASE_RESET;
        end else if (CE_I && VECTOR_TABLE_BASE_WE_I) begin
            vector_table_base_q <= VECTOR_TABLE_BASE_I;
        end
    end

    virq_arbiter #(
        .NV(NV)
    ) u_arb (
        .pend_i(pend),
        .level_i(level_all),
        .win_o(win)
    );

    // reset slot addresses
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            chip_reset_addr_q <= VECTOR_TABLE_BASE_RESET + OFS_CHIP_RESET;
            watchdog_reset_addr_q <= VECTOR_TABLE_BASE_RESET + OFS_WATCHDOG_RESET;
        end else if (CE_I) begin
            chip_reset_addr_q <= vector_table_base_q + OFS_CHIP_RESET;
            watchdog_reset_addr_q <= vector_table_base_q + OFS_WATCHDOG_RESET;
        end
    end

    // grant handshake
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
            grant_q <= '0;
        end else if (CE_I) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (win.valid) begin
                        state_q <= ST_HOLD;
                        grant_q.req <= 1'b1;
                        grant_q.level <= win.level;
                        grant_q.vector <= user_encoding(win.vector);
                        grant_q.addr <= vector_table_base_q + vec_offset(win.vector);
                    end
                end
                ST_HOLD: begin
                    if (ACK_I) begin
                        state_q <= ST_IDLE;
                        grant_q.req <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign GRANT_O = grant_q;
    assign CHIP_RESET_ADDR_O = chip_reset_addr_q;
    assign WATCHDOG_RESET_ADDR_O = watchdog_reset_addr_q;

    // assertions
    a_grant_held_stable: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (grant_q.req && !ACK_I) |=> (grant_q.req && $stable(grant_q.vector) && $stable(grant_q.level)))
        else $error("grant changed before acknowledge");
    a_addr_from_base: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && win.valid && !VECTOR_TABLE_BASE_WE_I) |=>
        (grant_q.addr == vector_table_base_q + {grant_q.vector, 1'b0}))
        else $error("fetch address not base plus offset");
    a_core_level_three: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (grant_q.req && grant_q.vector <= VEC_DBG_RX_FULL) |-> grant_q.level == CORE_LEVEL)
        else $error("core vector granted below level 3");
    a_core_beats_periph: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && CORE_EXC_I != 8'h00) |=> grant_q.vector <= VEC_DBG_RX_FULL)
        else $error("core exception lost to lower level");
    a_lowest_vec_wins: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && CORE_EXC_I[0]) |=> grant_q.vector == VEC_ILLEGAL)
        else $error("lowest vector did not win its level");
    a_level_reset_zero: assert property (@(posedge CLK_I)
        $rose(RST_N_I) |-> periph_level_q == '0)
        else $error("peripheral level not zero after reset");
    a_level_written: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (CE_I && PERIPH_LEVEL_WE_I) |=> periph_level_q == $past(PERIPH_LEVEL_I))
        else $error("peripheral level write lost");
    a_reset_slots: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        CE_I |=> (watchdog_reset_addr_q == chip_reset_addr_q + 19'h00002))
        else $error("watchdog slot not two words past reset slot");
    a_grant_on_pending: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && pend != '0) |=> grant_q.req)
        else $error("pending request not granted");
    a_spi_vectors: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && win.valid && win.vector == VEC_SPI_RX &&
         !VECTOR_TABLE_BASE_WE_I) |=> grant_q.addr == vector_table_base_q + 19'h00026)
        else $error("serial receive slot offset wrong");

    // handshake, reset slot, table base write and freeze checks
    a_ack_releases: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (grant_q.req && ACK_I && CE_I) |=> !grant_q.req)
        else $error("grant not released after acknowledge");

    a_hold_until_ack: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_HOLD && !ACK_I) |=> state_q == ST_HOLD)
        else $error("hold state left without acknowledge");

    a_req_with_state: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        grant_q.req == (state_q == ST_HOLD))
        else $error("grant request disagrees with state");

    a_no_reset_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        grant_q.req |-> grant_q.vector >= VEC_ILLEGAL)
        else $error("reset slot granted as interrupt");

    a_base_written: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (CE_I && VECTOR_TABLE_BASE_WE_I) |=> vector_table_base_q == $past(VECTOR_TABLE_BASE_I))
        else $error("table base write lost");

    a_frozen_state: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !CE_I |=> ($stable(periph_level_q) && $stable(grant_q) && $stable(vector_table_base_q)))
        else $error("state moved while clock enable low");

    // fixed slot offsets
    a_illegal_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_ILLEGAL) |=>
        grant_q.addr == vector_table_base_q + 19'h00004)
        else $error("illegal instruction slot offset wrong");

    a_misalign_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_MISALIGN) |=>
        grant_q.addr == vector_table_base_q + 19'h00008)
        else $error("misaligned access slot offset wrong");

    a_dbg_tx_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_DBG_TX_EMPTY) |=>
        grant_q.addr == vector_table_base_q + 19'h00010)
        else $error("debug transmit slot offset wrong");

    a_dbg_rx_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_DBG_RX_FULL) |=>
        grant_q.addr == vector_table_base_q + 19'h00012)
        else $error("debug receive slot offset wrong");

    a_power_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_POWER_MONITOR) |=>
        grant_q.addr == vector_table_base_q + 19'h00014)
        else $error("power monitor slot offset wrong");

    a_pwm_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_PWM) |=>
        grant_q.addr == vector_table_base_q + 19'h0001C)
        else $error("pulse width slot offset wrong");

    a_cmp0_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_CMP0) |=>
        grant_q.addr == vector_table_base_q + 19'h0001E)
        else $error("comparator 0 slot offset wrong");

    a_cmp2_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_CMP2) |=>
        grant_q.addr == vector_table_base_q + 19'h00022)
        else $error("comparator 2 slot offset wrong");

    a_flash_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_FLASH) |=>
        grant_q.addr == vector_table_base_q + 19'h00024)
        else $error("flash status slot offset wrong");

    a_spi_tx_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_SPI_TX) |=>
        grant_q.addr == vector_table_base_q + 19'h00028)
        else $error("serial transmit slot offset wrong");

    a_sci_tx_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_SCI_TX) |=>
        grant_q.addr == vector_table_base_q + 19'h0002A)
        else $error("async transmit slot offset wrong");

    a_sci_rx_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_SCI_RX) |=>
        grant_q.addr == vector_table_base_q + 19'h0002C)
        else $error("async receive slot offset wrong");

    a_timer0_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_DUAL_TIMER_CH0) |=>
        grant_q.addr == vector_table_base_q + 19'h00032)
        else $error("timer channel 0 slot offset wrong");

    a_timer1_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_DUAL_TIMER_CH1) |=>
        grant_q.addr == vector_table_base_q + 19'h00034)
        else $error("timer channel 1 slot offset wrong");

    a_port_a_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_PORT_A) |=>
        grant_q.addr == vector_table_base_q + 19'h00036)
        else $error("port A slot offset wrong");

    a_port_f_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_PORT_F) |=>
        grant_q.addr == vector_table_base_q + 19'h00040)
        else $error("port F slot offset wrong");

    a_rtc_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && CE_I && !VECTOR_TABLE_BASE_WE_I && win.valid && win.vector == VEC_RTC) |=>
        grant_q.addr == vector_table_base_q + 19'h00042)
        else $error("real time counter slot offset wrong");

    // main scenarios

    c_core_grant: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        grant_q.req && grant_q.level == CORE_LEVEL);
    c_periph_grant: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        grant_q.req && grant_q.vector == VEC_RTC);
    c_ack_cycle: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        grant_q.req ##1 ACK_I ##1 !grant_q.req);
    c_raised_level: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        grant_q.req && grant_q.vector >= VEC_POWER_MONITOR && grant_q.level != 2'h0);
    c_frozen_pending: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        !CE_I && pend != '0 && !grant_q.req);

endmodule

/* File: testbench/virq_core_model.sv */
// Purpose: behavioural core that acknowledges granted vectors
// Assumes: acks one grant at a time, after delay_i waiting cycles
// Notes: ack stands one cycle and is held until the edge that samples it
`timescale 1ns/1ps
module virq_core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // grant from the controller
    input virq_pkg::virq_grant_type grant_i,
    input wire logic [3:0] delay_i,
    // acknowledge to the controller
    output logic ack_o
);
    import virq_pkg::*;
    logic [3:0] wait_q;

    // only granted slots are acknowledged, one ack per grant
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o <= 1'b0;
            wait_q <= 4'h0;
        end else if (ack_o) begin
            ack_o <= 1'b0;
        end else if (grant_i.req && wait_q >= delay_i) begin
            ack_o <= 1'b1;
            wait_q <= 4'h0;
        end else if (grant_i.req) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

/* File: testbench/vectored_irq_priority_map_bench.sv */
// Purpose: self-checking bench for the vectored interrupt controller
// Assumes: core model acks grants; requests dropped at the ack edge
// Notes: clock enable dropped in one scenario only
`timescale 1ns/1ps
module vectored_irq_priority_map_bench;
    import virq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] core_exc = 8'h00;
    logic [23:0] periph_req = 24'h000000;
    logic [47:0] periph_level = 48'h000000000000;
    logic level_we = 1'b0;
    logic [18:0] base = 19'h00000;
    logic base_we = 1'b0;
    logic [3:0] delay = 4'h0;
    logic ack;
    virq_grant_type grant;
    logic [18:0] chip_addr;
    logic [18:0] wd_addr;
    int num_errors = 0;
    int samples_checked = 0;

    always #5 clk = ~clk;

    virq_ctrl i_virq_ctrl (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .CORE_EXC_I(core_exc),
        .PERIPH_REQ_I(periph_req), .PERIPH_LEVEL_I(periph_level), .PERIPH_LEVEL_WE_I(level_we),
        .VECTOR_TABLE_BASE_I(base), .VECTOR_TABLE_BASE_WE_I(base_we), .ACK_I(ack), .GRANT_O(grant),
        .CHIP_RESET_ADDR_O(chip_addr), .WATCHDOG_RESET_ADDR_O(wd_addr));
    virq_core_model i_virq_core_model (.clk_i(clk), .rst_n_i(rst_n), .grant_i(grant), .delay_i(delay),
        .ack_o(ack));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // wait for the ack edge, judge the grant, then drop the serviced request
    task automatic serve(input logic [5:0] v, input logic [1:0] lvl);
        virq_grant_type exp_g;
        virq_grant_type first;
        exp_g.req = 1'b1;
        exp_g.level = lvl;
        exp_g.vector = v;
        exp_g.addr = base + {12'h000, v, 1'b0};
        first = '0;
        repeat (40) begin
            @(posedge clk);
            if (first.req !== 1'b1) first = grant;
            if (ack === 1'b1 && grant.req === 1'b1) break;
        end
        check("grant", 32'(grant), 32'(exp_g));
        check("held grant", 32'(first), 32'(grant));
        if (v < 6'h0A) core_exc[v - 6'h02] <= 1'b0;
        else periph_req[v - 6'h0A] <= 1'b0;
    endtask

    task automatic t_reset;
        @(posedge clk);
        check("chip reset addr", 32'(chip_addr), 32'h00000000);
        check("watchdog reset addr", 32'(wd_addr), 32'h00000002);
        check("idle grant", 32'(grant), 32'h00000000);
    endtask

    // all core exceptions against default-level peripherals
    task automatic t_core;
        delay <= 4'h3;
        core_exc <= 8'hFF;
        periph_req <= 24'h800001;
        for (int v = 2; v <= 9; v++) serve(6'(v), 2'h3);
        serve(6'h0A, 2'h0);
        serve(6'h21, 2'h0);
    endtask

    // moved levels raise vectors 33, 25 and 14 above the other peripheral vectors
    task automatic t_levels;
        @(posedge clk);
        periph_level <= {2'h3, 14'h0000, 2'h2, 20'h00000, 2'h1, 8'h00};
        level_we <= 1'b1;
        delay <= 4'h0;
        @(posedge clk);
        level_we <= 1'b0;
        @(posedge clk);
        periph_req <= 24'hFFFFFF;
        serve(6'h21, 2'h3);
        serve(6'h19, 2'h2);
        serve(6'h0E, 2'h1);
        for (int v = 10; v <= 32; v++) begin
            if (v != 14 && v != 25) serve(6'(v), 2'h0);
        end
    endtask

    // base near the top of the 19-bit reach, fetch address wraps
    task automatic t_base;
        @(posedge clk);
        base <= 19'h7FFF0;
        base_we <= 1'b1;
        @(posedge clk);
        base_we <= 1'b0;
        repeat (3) @(posedge clk);
        check("chip reset addr", 32'(chip_addr), 32'h0007FFF0);
        check("watchdog reset addr", 32'(wd_addr), 32'h0007FFF2);
        periph_req[23] <= 1'b1;
        serve(6'h21, 2'h3);
    endtask

    // no grant while frozen, then the pending request is served
    task automatic t_freeze;
        ce <= 1'b0;
        periph_req[0] <= 1'b1;
        repeat (4) @(posedge clk);
        check("frozen grant", 32'(grant.req), 32'h00000000);
        ce <= 1'b1;
        serve(6'h0A, 2'h0);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_core;
        t_levels;
        t_freeze;
        t_base;
        complete_run;
    end

    initial begin
        #100000;
        num_errors++;
        complete_run;
    end
endmodule
